/* File: rtl/sabs_datapath.sv */
// Stack ALU, one-bit shift unit and zero/loop branch datapath
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - zero-test branch: load PC, N to T, pop
// - loop branch nonzero index: branch, decrement index
// - loop branch zero index: pop return stack
// - ALU uses head and second, result to head
// - Boolean functions leave carry untouched
// - Addition stores carry-out, optional carry-in
// - Carry is configuration bit 0, software accessible
// - Add/sub update carry; only three use it
// - Shift field shifts 16 or 32 bits
// - Codes 0-7 head only; others second/pair
// - 32-bit form: head high, second low
// - 0000 pass through; 0001 sign fill
// - 0010/0011 left shift, MSB to carry
// - 0100/0101 right through carry
// - 0110 logical right, zero top and carry
// - 0111 arithmetic right, bit 15 to carry
// - 1000/1001 shift second register left only
// - 1010/1011 32-bit left shift
// - 1100/1101 32-bit right through carry
// - 1110 32-bit logical right
// - 1111 32-bit arithmetic right
// - Branch target from block select and offset
//
module sabs_datapath
  import sabs_pkg::*;
(
  // Clock, reset and enable
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Operation request, one cycle each
  input wire logic op_valid_in,
  input wire logic [2:0] op_sel_in,
  input wire logic [3:0] alu_func_in,
  input wire logic [3:0] shift_sel_in,
  input wire logic [1:0] block_select_field_in,
  input wire logic [8:0] offset_in,
  // Program counter (already pointing at the following instruction)
  input wire logic [15:0] pc_in,
  // Stack controller data
  input wire logic [15:0] pstack_data_in,
  input wire logic [15:0] rstack_data_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Program counter load
  output logic pc_load_out,
  output logic [15:0] pc_target_out,
  // Stack controller strobes
  output logic pstack_pop_out,
  output logic rstack_pop_out,
  // Architectural state
  output logic [15:0] top_out,
  output logic [15:0] next_out,
  output logic [15:0] index_out,
  output logic carry_flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Branch target: new block bits, offset bits, bit 0 forced low
  function automatic logic [15:0] sabs_target(input logic [15:0] pc, input logic [1:0] blk,
                                              input logic [8:0] ofs);
    logic [5:0] block;
    block = pc[15:10];
    if (blk == SABS_BLK_NEXT) begin
      block = block + 6'h01;
    end else if (blk == SABS_BLK_ZERO) begin
      block = 6'h00;
    end else if (blk == SABS_BLK_PREV) begin
      block = block - 6'h01;
    end
    return {block, ofs, 1'b0};
  endfunction : sabs_target

  // 17-bit adder, carry-out in the top bit
  function automatic logic [16:0] sabs_add(input logic [15:0] a, input logic [15:0] b, input logic cin);
    return {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  endfunction : sabs_add

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] top_reg; // Stack head
  logic [15:0] next_reg; // Second stack register
  logic [15:0] index_reg; // Loop index register
  logic carry_reg; // Carry, bit 0 of the configuration register
  logic [15:0] top_next;
  logic [15:0] next_next;
  logic carry_next;

  // Combinational ALU and shifter
  logic [15:0] alu_z; // ALU output
  logic alu_carry; // Carry after the ALU step
  logic [16:0] sum; // Adder result

  ////////////////////////////////////////////////////////////////////////////
  // ALU: head is the first operand, second register the other, except in the swapped subtracts

  always_comb begin
    sum = 17'h00000;
    alu_z = top_reg;
    alu_carry = carry_reg;
    case (alu_func_in)
      SABS_ALU_AND: alu_z = top_reg & next_reg;
      SABS_ALU_NOR: alu_z = ~(top_reg | next_reg);
      SABS_ALU_OR: alu_z = top_reg | next_reg;
      SABS_ALU_XOR: alu_z = top_reg ^ next_reg;
      SABS_ALU_XNOR: alu_z = ~(top_reg ^ next_reg);
      SABS_ALU_ADD, SABS_ALU_ADDC: begin
        // Carry-in only for the with-carry form
        sum = sabs_add(top_reg, next_reg, (alu_func_in == SABS_ALU_ADDC) & carry_reg);
        alu_z = sum[15:0];
        alu_carry = sum[16];
      end
      SABS_ALU_SUB, SABS_ALU_SUBB: begin
        // Head minus second; without borrow the carry-in is one
        sum = sabs_add(top_reg, ~next_reg, (alu_func_in == SABS_ALU_SUBB) ? carry_reg : 1'b1);
        alu_z = sum[15:0];
        alu_carry = sum[16];
      end
      SABS_ALU_SUB_SW, SABS_ALU_SUB_SWB: begin
        // Swapped: second minus head
        sum = sabs_add(next_reg, ~top_reg, (alu_func_in == SABS_ALU_SUB_SWB) ? carry_reg : 1'b1);
        alu_z = sum[15:0];
        alu_carry = sum[16];
      end
      default: alu_z = top_reg; // Pass head, carry unchanged
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter: head is the high word, second register the low word

  always_comb begin
    top_next = alu_z;
    next_next = next_reg;
    carry_next = alu_carry;
    case (shift_sel_in)
      // Codes below eight touch only the head
      SABS_SH_NONE: top_next = alu_z;
      SABS_SH_SIGN: top_next = {16{alu_z[15]}};
      SABS_SH_LEFT, SABS_SH_LEFT_C: begin
        top_next = {alu_z[14:0], (shift_sel_in == SABS_SH_LEFT_C) ? alu_carry : 1'b0};
        carry_next = alu_z[15];
      end
      SABS_SH_RIGHT_CLR, SABS_SH_RIGHT_C: begin
        top_next = {alu_carry, alu_z[15:1]};
        carry_next = (shift_sel_in == SABS_SH_RIGHT_C) ? alu_z[0] : 1'b0;
      end
      SABS_SH_LOGICAL_RIGHT_16: begin
        top_next = {1'b0, alu_z[15:1]};
        carry_next = 1'b0;
      end
      SABS_SH_ARITH_RIGHT_16: begin
        top_next = {alu_z[15], alu_z[15:1]};
        carry_next = alu_z[15];
      end
      // Second register alone; head and carry keep the ALU result
      SABS_SH_NEXT_LEFT, SABS_SH_NEXT_LEFT_C: begin
        next_next = {next_reg[14:0], (shift_sel_in == SABS_SH_NEXT_LEFT_C) ? alu_carry : 1'b0};
      end
      SABS_SH_LEFT_32, SABS_SH_LEFT_32_C: begin
        top_next = {alu_z[14:0], next_reg[15]};
        next_next = {next_reg[14:0], (shift_sel_in == SABS_SH_LEFT_32_C) ? alu_carry : 1'b0};
        carry_next = alu_z[15];
      end
      SABS_SH_RIGHT_32_CLR, SABS_SH_RIGHT_32_C: begin
        top_next = {alu_carry, alu_z[15:1]};
        next_next = {alu_z[0], next_reg[15:1]};
        carry_next = (shift_sel_in == SABS_SH_RIGHT_32_C) ? next_reg[0] : 1'b0;
      end
      SABS_SH_LOGICAL_RIGHT_32: begin
        top_next = {1'b0, alu_z[15:1]};
        next_next = {alu_z[0], next_reg[15:1]};
        carry_next = 1'b0;
      end
      default: begin
        top_next = {alu_z[15], alu_z[15:1]};
        next_next = {alu_z[0], next_reg[15:1]};
        carry_next = alu_z[15];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded strobes

  logic do_alu;
  logic do_zero_br;
  logic do_loop;
  logic head_zero;
  logic index_zero;
  logic sw_wr_cfg;
  logic sw_wr_top;
  logic sw_wr_next;
  logic sw_wr_index;

  always_comb begin
    do_alu = op_valid_in && (op_sel_in == SABS_OP_ALU);
    do_zero_br = op_valid_in && (op_sel_in == SABS_OP_BR_ZERO);
    do_loop = op_valid_in && (op_sel_in == SABS_OP_BR_LOOP);
    head_zero = (top_reg == SABS_WORD_RST);
    index_zero = (index_reg == SABS_WORD_RST);
    sw_wr_cfg = 1'b0;
    sw_wr_top = 1'b0;
    sw_wr_next = 1'b0;
    sw_wr_index = 1'b0;
    if (reg_addr_in == SABS_ADDR_CFG) begin
      sw_wr_cfg = reg_wr_in;
    end else if (reg_addr_in == SABS_ADDR_TOP) begin
      sw_wr_top = reg_wr_in;
    end else if (reg_addr_in == SABS_ADDR_NEXT) begin
      sw_wr_next = reg_wr_in;
    end else begin
      sw_wr_index = reg_wr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Head and second register; operations win over software writes

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      top_reg <= SABS_WORD_RST;
      next_reg <= SABS_WORD_RST;
    end else if (clk_en_in) begin
      if (do_alu) begin
        top_reg <= top_next;
        next_reg <= next_next;
      end else if (do_zero_br && head_zero) begin
        top_reg <= next_reg;
        next_reg <= pstack_data_in;
      end else if (!do_zero_br && !do_loop) begin
        if (sw_wr_top) begin
          top_reg <= reg_wdata_in;
        end
        if (sw_wr_next) begin
          next_reg <= reg_wdata_in;
        end
      end
    end
  end

  // Carry flag: ALU step commits it, else software may set it
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      carry_reg <= SABS_CARRY_RST;
    end else if (clk_en_in) begin
      if (do_alu) begin
        carry_reg <= carry_next;
      end else if (sw_wr_cfg) begin
        carry_reg <= reg_wdata_in[SABS_CFG_CARRY_BIT];
      end
    end
  end

  // Loop index: decrement while nonzero, reload from return stack at zero
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      index_reg <= SABS_WORD_RST;
    end else if (clk_en_in) begin
      if (do_loop) begin
        if (!index_zero) begin
          index_reg <= index_reg - 16'h0001;
        end else begin
          index_reg <= rstack_data_in;
        end
      end else if (sw_wr_index) begin
        index_reg <= reg_wdata_in;
      end
    end
  end

  // Program counter load and stack pops, one-cycle pulses
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pc_load_out <= 1'b0;
      pc_target_out <= SABS_PC_RST;
      pstack_pop_out <= 1'b0;
      rstack_pop_out <= 1'b0;
    end else if (clk_en_in) begin
      pc_load_out <= (do_zero_br && head_zero) || (do_loop && !index_zero);
      pc_target_out <= sabs_target(pc_in, block_select_field_in, offset_in);
      pstack_pop_out <= do_zero_br && head_zero;
      rstack_pop_out <= do_loop && index_zero;
    end else begin
      // Frozen cycles must not repeat a pulse
      pc_load_out <= 1'b0;
      pstack_pop_out <= 1'b0;
      rstack_pop_out <= 1'b0;
    end
  end

  // Read data, one cycle after the read strobe; zero after other enabled cycles, held while frozen
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= SABS_WORD_RST;
    end else if (clk_en_in) begin
      if (!reg_rd_in) begin
        reg_rdata_out <= SABS_WORD_RST;
      end else if (reg_addr_in == SABS_ADDR_CFG) begin
        reg_rdata_out <= {15'h0000, carry_reg};
      end else if (reg_addr_in == SABS_ADDR_TOP) begin
        reg_rdata_out <= top_reg;
      end else if (reg_addr_in == SABS_ADDR_NEXT) begin
        reg_rdata_out <= next_reg;
      end else begin
        reg_rdata_out <= index_reg;
      end
    end
  end

  // State mirrors, frozen together with the state they copy
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      top_out <= SABS_WORD_RST;
      next_out <= SABS_WORD_RST;
      index_out <= SABS_WORD_RST;
      carry_flag_out <= SABS_CARRY_RST;
    end else if (clk_en_in) begin
      top_out <= top_reg;
      next_out <= next_reg;
      index_out <= index_reg;
      carry_flag_out <= carry_reg;
    end
  end

endmodule : sabs_datapath
`default_nettype wire

/* File: rtl/sabs_pkg.sv */
// Package: constants for the stack ALU, shift and branch datapath
package sabs_pkg;

  // Data path width
  localparam int SABS_W = 16;

  // Reset values
  localparam logic [15:0] SABS_WORD_RST = 16'h0000;
  localparam logic [15:0] SABS_PC_RST = 16'h0000;
  localparam logic SABS_CARRY_RST = 1'b0;

  // Configuration register field position of the carry flag
  localparam int SABS_CFG_CARRY_BIT = 0;
  localparam logic [15:0] SABS_CFG_RST = 16'h0000;

  // Register map of the plain register port (indices)
  localparam logic [1:0] SABS_ADDR_CFG = 2'h0;
  localparam logic [1:0] SABS_ADDR_TOP = 2'h1;
  localparam logic [1:0] SABS_ADDR_NEXT = 2'h2;
  localparam logic [1:0] SABS_ADDR_INDEX = 2'h3;

  // Operation select
  localparam logic [2:0] SABS_OP_NONE = 3'h0;
  localparam logic [2:0] SABS_OP_BR_ZERO = 3'h1;
  localparam logic [2:0] SABS_OP_BR_LOOP = 3'h2;
  localparam logic [2:0] SABS_OP_ALU = 3'h3;

  // ALU function codes
  localparam logic [3:0] SABS_ALU_PASS = 4'h0;
  localparam logic [3:0] SABS_ALU_AND = 4'h2;
  localparam logic [3:0] SABS_ALU_NOR = 4'h3;
  localparam logic [3:0] SABS_ALU_SUB_SW = 4'h4;
  localparam logic [3:0] SABS_ALU_SUB_SWB = 4'h5;
  localparam logic [3:0] SABS_ALU_OR = 4'h7;
  localparam logic [3:0] SABS_ALU_ADD = 4'h8;
  localparam logic [3:0] SABS_ALU_ADDC = 4'h9;
  localparam logic [3:0] SABS_ALU_XOR = 4'hA;
  localparam logic [3:0] SABS_ALU_XNOR = 4'hB;
  localparam logic [3:0] SABS_ALU_SUB = 4'hC;
  localparam logic [3:0] SABS_ALU_SUBB = 4'hD;

  // Shift codes
  localparam logic [3:0] SABS_SH_NONE = 4'h0;
  localparam logic [3:0] SABS_SH_SIGN = 4'h1;
  localparam logic [3:0] SABS_SH_LEFT = 4'h2;
  localparam logic [3:0] SABS_SH_LEFT_C = 4'h3;
  localparam logic [3:0] SABS_SH_RIGHT_CLR = 4'h4;
  localparam logic [3:0] SABS_SH_RIGHT_C = 4'h5;
  localparam logic [3:0] SABS_SH_LOGICAL_RIGHT_16 = 4'h6;
  localparam logic [3:0] SABS_SH_ARITH_RIGHT_16 = 4'h7;
  localparam logic [3:0] SABS_SH_NEXT_LEFT = 4'h8;
  localparam logic [3:0] SABS_SH_NEXT_LEFT_C = 4'h9;
  localparam logic [3:0] SABS_SH_LEFT_32 = 4'hA;
  localparam logic [3:0] SABS_SH_LEFT_32_C = 4'hB;
  localparam logic [3:0] SABS_SH_RIGHT_32_CLR = 4'hC;
  localparam logic [3:0] SABS_SH_RIGHT_32_C = 4'hD;
  localparam logic [3:0] SABS_SH_LOGICAL_RIGHT_32 = 4'hE;
  localparam logic [3:0] SABS_SH_ARITH_RIGHT_32 = 4'hF;

  // Block select codes
  localparam logic [1:0] SABS_BLK_SAME = 2'h0;
  localparam logic [1:0] SABS_BLK_NEXT = 2'h1;
  localparam logic [1:0] SABS_BLK_ZERO = 2'h2;
  localparam logic [1:0] SABS_BLK_PREV = 2'h3;

endpackage : sabs_pkg

/* File: dv/sabs_datapath_checker.sv */
// Concurrent checks on the ports of the stack ALU, shift and branch datapath
`timescale 1ns/1ps
`default_nettype none
module sabs_datapath_checker
  import sabs_pkg::*;
(
  // Clock, reset and enable
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Requests
  input wire logic op_valid_in,
  input wire logic [2:0] op_sel_in,
  input wire logic [1:0] block_select_field_in,
  input wire logic [8:0] offset_in,
  input wire logic [15:0] pc_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  // Answers
  input wire logic [15:0] reg_rdata_out,
  input wire logic pc_load_out,
  input wire logic [15:0] pc_target_out,
  input wire logic pstack_pop_out,
  input wire logic rstack_pop_out
);
  // One clock domain, so one default clock and disable
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////////////////
  // Stack strobes and program counter load
  AST_PC_LOAD_CAUSE: assert property (pc_load_out |->
    $past(op_valid_in && clk_en_in && op_sel_in != SABS_OP_ALU && op_sel_in != SABS_OP_NONE))
    else $error("pc load without a branch request");
  AST_PSTACK_POP: assert property (pstack_pop_out |->
    $past(op_valid_in && op_sel_in == SABS_OP_BR_ZERO) && pc_load_out)
    else $error("parameter pop without a taken zero branch");
  AST_RSTACK_POP: assert property (rstack_pop_out |->
    $past(op_valid_in && op_sel_in == SABS_OP_BR_LOOP) && !pc_load_out)
    else $error("return pop outside an exhausted loop");
  AST_LOOP_ONE_WAY: assert property ((op_valid_in && clk_en_in && op_sel_in == SABS_OP_BR_LOOP) |=>
    !pstack_pop_out && (pc_load_out ^ rstack_pop_out))
    else $error("loop branch neither branched nor popped once");
  // A frozen cycle must never repeat or raise a pulse
  AST_FREEZE_NO_PULSE: assert property (!clk_en_in |=>
    !pc_load_out && !pstack_pop_out && !rstack_pop_out)
    else $error("pulse raised in a frozen cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Branch target forming
  AST_TARGET_LOW: assert property (clk_en_in |=> pc_target_out[9:0] == {$past(offset_in), 1'b0})
    else $error("target offset or word alignment wrong");
  AST_BLK_SAME: assert property ((clk_en_in && block_select_field_in == SABS_BLK_SAME) |=>
    pc_target_out[15:10] == $past(pc_in[15:10]))
    else $error("same block target wrong");
  AST_BLK_NEXT: assert property ((clk_en_in && block_select_field_in == SABS_BLK_NEXT) |=>
    pc_target_out[15:10] == $past(pc_in[15:10]) + 6'h01)
    else $error("next block target wrong");
  AST_BLK_ZERO: assert property ((clk_en_in && block_select_field_in == SABS_BLK_ZERO) |=>
    pc_target_out[15:10] == 6'h00)
    else $error("block zero target wrong");
  AST_BLK_PREV: assert property ((clk_en_in && block_select_field_in == SABS_BLK_PREV) |=>
    pc_target_out[15:10] == $past(pc_in[15:10]) - 6'h01)
    else $error("previous block target wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Carry is software visible in the configuration register
  AST_CFG_READBACK: assert property (
    (reg_wr_in && reg_addr_in == SABS_ADDR_CFG && !op_valid_in && clk_en_in) ##1
    (reg_rd_in && reg_addr_in == SABS_ADDR_CFG && !op_valid_in && clk_en_in) |=>
    reg_rdata_out[0] == $past(reg_wdata_in[0], 2))
    else $error("carry write not read back");
endmodule : sabs_datapath_checker
`default_nettype wire

// Attach beside every datapath instance
bind sabs_datapath sabs_datapath_checker u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
  .op_valid_in(op_valid_in), .op_sel_in(op_sel_in), .block_select_field_in(block_select_field_in),
  .offset_in(offset_in), .pc_in(pc_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pc_load_out(pc_load_out),
  .pc_target_out(pc_target_out), .pstack_pop_out(pstack_pop_out), .rstack_pop_out(rstack_pop_out));

/* File: dv/tb_top.sv */
// Self-checking testbench for the stack ALU, shift and branch datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sabs_pkg::*;
;
  // Design inputs, all defined at time zero
  logic core_clk_in = 1'b0, rstn_in = 1'b0, op_valid_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [2:0] op_sel_in = 3'h0;
  logic [3:0] alu_func_in = 4'h0, shift_sel_in = 4'h0;
  logic [1:0] block_select_field_in = 2'h0, reg_addr_in = 2'h0;
  logic [8:0] offset_in = 9'h000;
  logic [15:0] pc_in = 16'h0000, pstack_data_in = 16'h0000, rstack_data_in = 16'h0000, reg_wdata_in = 16'h0000;
  // Design outputs
  logic [15:0] reg_rdata_out, pc_target_out, top_out, next_out, index_out;
  logic pc_load_out, pstack_pop_out, rstack_pop_out, carry_flag_out;
  // Reference state and pending results
  logic [15:0] m_top = 16'h0000, m_next = 16'h0000, m_idx = 16'h0000;
  logic m_carry = 1'b0, rd_d = 1'b0, op_d = 1'b0;
  logic [3:0] fn = 4'h0, sh = 4'h0;
  logic [15:0] rd_q[$];
  logic [18:0] op_q[$];
  int mismatches = 0, cmp_count = 0, cycles = 0, seed = 62404;

  // Device under test; the enable is driven so that freezing is exercised
  sabs_datapath dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .op_valid_in(op_valid_in),
    .op_sel_in(op_sel_in), .alu_func_in(alu_func_in), .shift_sel_in(shift_sel_in),
    .block_select_field_in(block_select_field_in), .offset_in(offset_in), .pc_in(pc_in),
    .pstack_data_in(pstack_data_in), .rstack_data_in(rstack_data_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .pstack_pop_out(pstack_pop_out),
    .rstack_pop_out(rstack_pop_out), .top_out(top_out), .next_out(next_out), .index_out(index_out),
    .carry_flag_out(carry_flag_out));

  // 25 MHz clock
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference ALU then shift; returns carry, head, second
  function automatic logic [32:0] ref_alu(input logic [3:0] f, input logic [3:0] s, input logic [15:0] t,
                                          input logic [15:0] n, input logic c);
    logic [16:0] z;
    logic [15:0] nn;
    case (f)
      4'h2: z = {c, t & n};
      4'h3: z = {c, ~(t | n)};
      4'h4: z = {1'b0, n} + {1'b0, ~t} + 17'h00001;
      4'h5: z = {1'b0, n} + {1'b0, ~t} + {16'h0000, c};
      4'h7: z = {c, t | n};
      4'h8: z = {1'b0, t} + {1'b0, n};
      4'h9: z = {1'b0, t} + {1'b0, n} + {16'h0000, c};
      4'hA: z = {c, t ^ n};
      4'hB: z = {c, ~(t ^ n)};
      4'hC: z = {1'b0, t} + {1'b0, ~n} + 17'h00001;
      4'hD: z = {1'b0, t} + {1'b0, ~n} + {16'h0000, c};
      default: z = {c, t};
    endcase
    // Shift sees the carry left by the ALU step
    c = z[16];
    nn = n;
    case (s)
      4'h1: z[15:0] = {16{z[15]}};
      4'h2, 4'h3: z = {z[15], z[14:0], s[0] & c};
      4'h4, 4'h5: z = {s[0] & z[0], c, z[15:1]};
      4'h6: z = {2'b00, z[15:1]};
      4'h7: z = {z[15], z[15], z[15:1]};
      4'h8, 4'h9: nn = {n[14:0], s[0] & c};
      4'hA, 4'hB: {z, nn} = {z[15], z[14:0], n[15], n[14:0], s[0] & c};
      4'hC, 4'hD: {z, nn} = {s[0] & n[0], c, z[15:0], n[15:1]};
      4'hE: {z, nn} = {2'b00, z[15:0], n[15:1]};
      4'hF: {z, nn} = {z[15], z[15], z[15:0], n[15:1]};
      default: nn = n;
    endcase
    return {z, nn};
  endfunction : ref_alu

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One bus cycle; side data random each cycle; notes the expected answer
  task automatic cyc(input logic v, input logic [2:0] sel, input logic wr, input logic rd, input logic [1:0] a,
                     input logic [15:0] d);
    logic [1:0] b;
    logic [8:0] o;
    logic [15:0] p, ps, rs, tg;
    logic [18:0] e;
    b = 2'($random(seed));
    o = 9'($random(seed));
    p = 16'($random(seed));
    ps = 16'($random(seed));
    rs = 16'($random(seed));
    tg = {(b == 2'h0) ? p[15:10] : (b == 2'h1) ? p[15:10] + 6'h01 : (b == 2'h2) ? 6'h00 : p[15:10] - 6'h01, o, 1'b0};
    e = 19'h00000;
    @(posedge core_clk_in);
    op_valid_in <= v;
    op_sel_in <= sel;
    reg_wr_in <= wr;
    reg_rd_in <= rd;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    alu_func_in <= fn;
    shift_sel_in <= sh;
    block_select_field_in <= b;
    offset_in <= o;
    pc_in <= p;
    pstack_data_in <= ps;
    rstack_data_in <= rs;
    if (rd) begin
      rd_q.push_back((a == 2'h0) ? {15'h0000, m_carry} : (a == 2'h1) ? m_top : (a == 2'h2) ? m_next : m_idx);
    end
    if (wr) begin
      case (a)
        2'h0: m_carry = d[0];
        2'h1: m_top = d;
        2'h2: m_next = d;
        default: m_idx = d;
      endcase
    end
    if (v && sel == SABS_OP_ALU) begin
      {m_carry, m_top, m_next} = ref_alu(fn, sh, m_top, m_next, m_carry);
    end else if (v && sel == SABS_OP_BR_ZERO && m_top == 16'h0000) begin
      e = {3'b101, tg};
      m_top = m_next;
      m_next = ps;
    end else if (v && sel == SABS_OP_BR_LOOP && m_idx != 16'h0000) begin
      e = {3'b100, tg};
      m_idx = m_idx - 16'h0001;
    end else if (v && sel == SABS_OP_BR_LOOP) begin
      e = {3'b010, 16'h0000};
      m_idx = rs;
    end
    if (v) begin
      op_q.push_back(e);
    end
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: takes the oldest note as each result appears
  always @(posedge core_clk_in) begin
    if (rd_d) check({17'h00000, reg_rdata_out}, {17'h00000, rd_q.pop_front()});
    if (op_d) check({14'h0000, pc_load_out, rstack_pop_out, pstack_pop_out, pc_load_out ? pc_target_out : 16'h0000},
                    {14'h0000, op_q.pop_front()});
    // A request in a frozen cycle is not taken, so it expects no answer
    rd_d <= reg_rd_in && rstn_in && clk_en_in;
    op_d <= op_valid_in && rstn_in && clk_en_in;
  end

  // Hang guard, about twice the expected run
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    // Reset values of all four registers
    for (int a = 0; a < 4; a++) cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, 2'(a), 16'h0000);
    $display("Test reset values done");
    // Every ALU code with every shift code, each on freshly written head, second and carry
    for (int i = 0; i < 256; i++) begin
      fn = 4'(i);
      sh = 4'(i >> 4);
      cyc(1'b0, SABS_OP_NONE, 1'b1, 1'b0, SABS_ADDR_TOP, 16'($random(seed)));
      cyc(1'b0, SABS_OP_NONE, 1'b1, 1'b0, SABS_ADDR_NEXT, 16'($random(seed)));
      cyc(1'b0, SABS_OP_NONE, 1'b1, 1'b0, SABS_ADDR_CFG, 16'($random(seed)));
      cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, SABS_ADDR_CFG, 16'h0000);
      cyc(1'b1, SABS_OP_ALU, 1'b0, 1'b0, 2'h0, 16'h0000);
      for (int a = 0; a < 3; a++) cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, 2'(a), 16'h0000);
    end
    $display("Test alu and shift done");
    // Zero-test branch with a zero and a nonzero head
    for (int i = 0; i < 16; i++) begin
      cyc(1'b0, SABS_OP_NONE, 1'b1, 1'b0, SABS_ADDR_TOP, i[0] ? 16'($random(seed)) | 16'h0100 : 16'h0000);
      cyc(1'b1, SABS_OP_BR_ZERO, 1'b0, 1'b0, 2'h0, 16'h0000);
      cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, SABS_ADDR_TOP, 16'h0000);
      cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, SABS_ADDR_NEXT, 16'h0000);
    end
    $display("Test zero branch done");
    // Loop branch counting down through zero, back to back
    for (int k = 0; k < 4; k++) begin
      cyc(1'b0, SABS_OP_NONE, 1'b1, 1'b0, SABS_ADDR_INDEX, 16'(k));
      repeat (k + 2) cyc(1'b1, SABS_OP_BR_LOOP, 1'b0, 1'b0, 2'h0, 16'h0000);
      cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, SABS_ADDR_INDEX, 16'h0000);
    end
    $display("Test loop branch done");
    // Frozen cycles: a loop step and a head write must leave all state alone
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    reg_rd_in <= 1'b0;
    op_valid_in <= 1'b1;
    op_sel_in <= SABS_OP_BR_LOOP;
    @(posedge core_clk_in);
    op_valid_in <= 1'b0;
    reg_wr_in <= 1'b1;
    reg_addr_in <= SABS_ADDR_TOP;
    reg_wdata_in <= ~m_top;
    @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    reg_wr_in <= 1'b0;
    cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b1, SABS_ADDR_INDEX, 16'h0000);
    repeat (3) cyc(1'b0, SABS_OP_NONE, 1'b0, 1'b0, 2'h0, 16'h0000);
    check({carry_flag_out, top_out, next_out}, {m_carry, m_top, m_next});
    check({17'h00000, index_out}, {17'h00000, m_idx});
    $display("Test freeze done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
